// File: hdl/bscd_pkg.sv
// Constants, store layout and types for the bridge correction core.
// Assumes a 20 MHz core clock and a byte-wide coefficient store.
package bscd_pkg;

	localparam int CLK_HZ         = 20_000_000;
	localparam int CLK_PER_US     = CLK_HZ / 1_000_000;
	localparam int CONV_PERIOD_US = 1000;
	localparam int CONV_CYC       = CONV_PERIOD_US * CLK_PER_US;
	localparam int NV_PROG_US     = 6000;
	localparam int NV_PROG_CYC    = NV_PROG_US * CLK_PER_US;

	localparam int AW  = 8;
	localparam int NVB = 21;

	localparam logic [AW-1:0] A_STATUS = 8'h00;
	localparam logic [AW-1:0] A_NV     = 8'h04;
	localparam logic [AW-1:0] A_RAW_BR = 8'h08;
	localparam logic [AW-1:0] A_RAW_T  = 8'h0C;
	localparam logic [AW-1:0] A_RESULT = 8'h10;
	localparam logic [AW-1:0] A_TEMP   = 8'h14;
	localparam logic [AW-1:0] A_CMD    = 8'h18;

	localparam logic [7:0] CMD_CAL_LOW = 8'h01;

	// Byte positions inside the store
	localparam int B_CFG   = 0;
	localparam int B_RATE  = 1;
	localparam int B_UP    = 2;
	localparam int B_LO    = 3;
	localparam int B_GAINB = 4;
	localparam int B_OFFB  = 6;
	localparam int B_TCG   = 8;
	localparam int B_TCO   = 10;
	localparam int B_SOT   = 12;
	localparam int B_TSETL = 14;
	localparam int B_GAINT = 16;
	localparam int B_OFFT  = 17;
	localparam int B_CUST  = 18;

	// Bit positions inside the configuration byte
	localparam int CFG_GAIN  = 0;
	localparam int CFG_FLIP  = 2;
	localparam int CFG_ZP    = 3;
	localparam int CFG_SOT   = 5;
	localparam int CFG_OSIGN = 7;

	localparam logic [1:0] SOT_BR  = 2'h0;
	localparam logic [1:0] SOT_TCO = 2'h1;
	localparam logic [1:0] SOT_TCG = 2'h2;

	localparam logic [1:0] SEL_AZ = 2'h0;
	localparam logic [1:0] SEL_BR = 2'h1;
	localparam logic [1:0] SEL_T  = 2'h2;

	// Fixed-point scaling of the correction datapath
	localparam logic signed [63:0] ONE_Q14  = 64'sh4000;
	localparam logic signed [63:0] K125_Q14 = 64'sh5000;
	localparam logic signed [63:0] SAT_MAX  = 64'sh3FFF;
	localparam int SH_SOT = 12;
	localparam int SH_TC  = 8;
	localparam int SH_G   = 12;
	localparam int SH_Z   = 14;
	localparam int SH_T   = 5;

	typedef enum logic [1:0] {ST_LOAD, ST_WAIT, ST_CONV, ST_CALC} bscd_state_t;

	function automatic logic [6:0] bscd_rate_mult(input logic [1:0] code);
		case (code)
			2'h0:    return 7'h01;
			2'h1:    return 7'h05;
			2'h2:    return 7'h14;
			default: return 7'h64;
		endcase
	endfunction : bscd_rate_mult

endpackage : bscd_pkg

// File: hdl/bscd_core.sv
// Digital core of a bridge sensor conditioner: conversion sequencer,
// coefficient store, correction datapath, clipping and output latch.
// Assumes an external converter with start/done handshake and a host
// register port synchronous to mclk.
//
// Summary of operation
// (R1) Temperature uses upper 12 converter bits
// (R2) Digital temperature output is top 8 bits
// (R3) Bridge sink on only during each conversion
// (R4) Preamp gain select decoded from stored field
// (R5) Stored bit swaps bridge inputs
// (R6) Auto-zero conversion nulls preamp drift
// (R7) Converter delivers 14-bit bridge and temperature results
// (R8) Stored field picks one of four zero points
// (R9) Conversion rate follows rate setting, fastest 1k/s
// (R10) One second-order term, one selected target
// (R11) Second-order term applied on bridge reading
// (R12) Second-order term applied on offset coefficient
// (R13) Second-order term applied on gain coefficient
// (R14) Delta temperature is raw minus low point
// (R15) Sign bit selects offset subtract or add
// (R16) Temperature corrected linearly with gain and offset
// (R17) Store read shifts eight bits per byte
// (R18) Store write busy for six milliseconds
// (R19) Store holds three traceability bytes
// (R20) Host commands: raw reads, calibration, dump, writes
// (R21) Thresholds built from seven-bit limit fields
// (R22) Corrected value clipped to thresholds
// (R23) Clipped result drives 12-bit output converter
// (R24) Conversion and link timing derive from core clock
// (R25) Results saturate to 14-bit range
// (R26) Coefficients loaded from store after reset
`timescale 1ns/1ps

module bscd_core #(
	parameter int unsigned CONV_CYC_P    = bscd_pkg::CONV_CYC,
	parameter int unsigned NV_PROG_CYC_P = bscd_pkg::NV_PROG_CYC
) (
	input  wire logic                    mclk,
	input  wire logic                    reset,
	input  wire logic [bscd_pkg::AW-1:0] bus_addr,
	input  wire logic [31:0]             bus_wdata,
	input  wire logic                    bus_wr,
	input  wire logic                    bus_rd,
	output logic      [31:0]             bus_rdata,
	output logic                         adc_start,
	output logic      [1:0]              adc_sel,
	input  wire logic                    adc_done,
	input  wire logic [13:0]             adc_data,
	output logic                         bridge_sink_on,
	output logic      [1:0]              pamp_gain_sel,
	output logic                         polarity_flip,
	output logic      [1:0]              adc_zero_point_select,
	output logic      [11:0]             dac_data,
	output logic      [13:0]             dig_bridge,
	output logic      [7:0]              dig_temp,
	output logic                         out_valid
);
	import bscd_pkg::*;

	typedef struct packed {
		bscd_state_t         st;
		logic [NVB-1:0][7:0] nv;
		logic [NVB-1:0][7:0] sh;
		logic [4:0]          idx;
		logic [23:0]         tick_cnt;
		logic [16:0]         busy_cnt;
		logic                loaded;
		logic                start;
		logic [1:0]          sel;
		logic                sink;
		logic [13:0]         az;
		logic [13:0]         br;
		logic [13:0]         traw;
		logic [11:0]         dac;
		logic [13:0]         res;
		logic [7:0]          temp;
		logic                valid;
		logic [31:0]         rdata;
	} bscd_regs_t;

	bscd_regs_t s_r;
	bscd_regs_t s_nxt;

	logic signed [63:0] dt;
	logic signed [63:0] sq;
	logic signed [63:0] tco_e;
	logic signed [63:0] tcg_e;
	logic signed [63:0] xb;
	logic signed [63:0] gf;
	logic signed [63:0] gb;
	logic signed [63:0] zbs;
	logic signed [63:0] rb_w;
	logic signed [63:0] gts;
	logic signed [63:0] t12s;
	logic signed [63:0] offt;
	logic signed [63:0] tw;
	logic        [13:0] zb;
	logic        [13:0] rb;
	logic        [13:0] up_th;
	logic        [13:0] lo_th;
	logic        [13:0] clip;
	logic        [13:0] tc14;
	logic        [1:0]  tgt;
	logic               nv_ok;
	logic               slot;

	function automatic logic signed [63:0] cw(input logic [NVB-1:0][7:0] a, input int i);
		return 64'($signed({a[i+1], a[i]}));
	endfunction : cw

	// Clamp instead of wrap so an overrange bridge reads full scale
	function automatic logic [13:0] sat14(input logic signed [63:0] v);
		if (v < 0)
			return 14'h0000;
		else if (v > SAT_MAX)
			return 14'h3FFF;
		else
			return v[13:0];
	endfunction : sat14

	// Correction datapath, evaluated combinationally from the latest samples
	assign tgt   = s_r.sh[B_CFG][CFG_SOT+:2]; // R10
	assign dt    = 64'($signed({1'b0, s_r.traw[13:2]}))
	             - 64'($signed({1'b0, s_r.sh[B_TSETL+1][3:0], s_r.sh[B_TSETL]})); // R1 R14
	assign sq    = (cw(s_r.sh, B_SOT) * dt) >>> SH_SOT;
	assign tco_e = cw(s_r.sh, B_TCO) + ((tgt == SOT_TCO) ? sq : 64'sh0); // R12
	assign tcg_e = cw(s_r.sh, B_TCG) + ((tgt == SOT_TCG) ? sq : 64'sh0); // R13
	assign xb    = 64'($signed({1'b0, s_r.br})) - 64'($signed({1'b0, s_r.az})) // R6
	             + (s_r.sh[B_CFG][CFG_OSIGN] ? cw(s_r.sh, B_OFFB) : -cw(s_r.sh, B_OFFB)) // R15
	             + ((dt * tco_e) >>> SH_TC);
	assign gf    = ONE_Q14 + ((dt * tcg_e) >>> SH_TC);
	assign gb    = (cw(s_r.sh, B_GAINB) * gf) >>> SH_G;
	assign zb    = sat14((gb * xb) >>> SH_Z); // R25
	assign zbs   = {50'h0, zb};
	assign rb_w  = (zbs * (K125_Q14 + ((cw(s_r.sh, B_SOT) * zbs) >>> SH_Z))) >>> SH_Z; // R11
	assign rb    = (tgt == SOT_BR) ? sat14(rb_w) : zb; // R25

	assign up_th = {2'h3, s_r.sh[B_UP][6:0], 5'h1F}; // R21
	assign lo_th = {2'h0, s_r.sh[B_LO][6:0], 5'h00}; // R21
	assign clip  = (rb > up_th) ? up_th : ((rb < lo_th) ? lo_th : rb); // R22

	// Temperature: linear only, the reference is already very linear
	assign gts   = {56'h0, s_r.sh[B_GAINT]};
	assign t12s  = {52'h0, s_r.traw[13:2]}; // R1
	assign offt  = 64'($signed(s_r.sh[B_OFFT]));
	assign tw    = (gts * (t12s + offt)) >>> SH_T; // R16
	assign tc14  = sat14(tw);

	// Store is usable only when not loading and not programming
	assign nv_ok = s_r.loaded && (s_r.st != ST_LOAD) && (s_r.busy_cnt == 17'h0);
	assign slot  = s_r.loaded && (s_r.tick_cnt == 24'h0);

	always_comb begin
		s_nxt = s_r;
		s_nxt.start = 1'b0;
		s_nxt.valid = 1'b0;
		s_nxt.rdata = 32'h0000_0000;

		// Slot timer, one conversion per slot
		if (s_r.loaded) begin
			if (slot)
				s_nxt.tick_cnt = 24'(CONV_CYC_P * bscd_rate_mult(s_r.sh[B_RATE][1:0])) - 24'h1; // R9 R24
			else
				s_nxt.tick_cnt = s_r.tick_cnt - 24'h1;
		end

		case (s_r.st)
			ST_LOAD: begin
				// Full rotation leaves the store in its original order
				s_nxt.sh[s_r.idx] = s_r.nv[0]; // R26
				s_nxt.nv = {s_r.nv[0], s_r.nv[NVB-1:1]}; // R19
				if (s_r.idx == 5'(NVB - 1)) begin
					s_nxt.idx = 5'h00;
					s_nxt.loaded = 1'b1;
					s_nxt.sel = SEL_AZ;
					s_nxt.st = ST_WAIT;
				end else begin
					s_nxt.idx = s_r.idx + 5'h01;
				end
			end
			ST_WAIT: begin
				if (slot) begin
					s_nxt.start = 1'b1;
					s_nxt.sink = 1'b1; // R3
					s_nxt.st = ST_CONV;
				end
			end
			ST_CONV: begin
				if (adc_done) begin
					s_nxt.sink = 1'b0; // R3
					case (s_r.sel)
						SEL_AZ:  s_nxt.az = adc_data; // R6 R7
						SEL_BR:  s_nxt.br = adc_data; // R7
						default: s_nxt.traw = adc_data; // R7
					endcase
					if (s_r.sel == SEL_T) begin
						s_nxt.st = ST_CALC;
					end else begin
						s_nxt.sel = s_r.sel + 2'h1;
						s_nxt.st = ST_WAIT;
					end
				end
			end
			ST_CALC: begin
				s_nxt.res = clip; // R22
				s_nxt.dac = clip[13:2]; // R23
				s_nxt.temp = tc14[13:6]; // R2
				s_nxt.valid = 1'b1;
				s_nxt.sel = SEL_AZ;
				s_nxt.st = ST_WAIT;
			end
			default: begin
				s_nxt.st = ST_LOAD;
			end
		endcase

		// Programming time, then refresh the working coefficients
		if (s_r.busy_cnt != 17'h0) begin
			s_nxt.busy_cnt = s_r.busy_cnt - 17'h1; // R18
			if (s_r.busy_cnt == 17'h1) begin
				s_nxt.st = ST_LOAD; // R26
				s_nxt.idx = 5'h00;
				// An aborted slot must not launch a conversion
				s_nxt.start = 1'b0;
				s_nxt.sink = 1'b0;
			end
		end

		// Host command port
		if (bus_wr) begin
			case (bus_addr)
				A_NV: begin
					if (nv_ok) begin
						s_nxt.nv = {bus_wdata[7:0], s_r.nv[NVB-1:1]}; // R20
						s_nxt.busy_cnt = 17'(NV_PROG_CYC_P); // R18
					end
				end
				A_CMD: begin
					// Low calibration point lives in the working copy only
					if (bus_wdata[7:0] == CMD_CAL_LOW) begin
						s_nxt.sh[B_TSETL] = s_r.traw[9:2]; // R14 R20
						s_nxt.sh[B_TSETL+1] = {4'h0, s_r.traw[13:10]};
					end
				end
				default: begin
				end
			endcase
		end else if (bus_rd) begin
			case (bus_addr)
				// Busy covers the reload too, so a poller never hits a refused slot
				A_STATUS: s_nxt.rdata = {28'h000_0000, s_r.loaded,
				                         (s_r.busy_cnt != 17'h0) || (s_r.st == ST_LOAD), // R18
				                         s_r.st == ST_CONV, s_r.sink};
				A_NV: begin
					if (nv_ok) begin
						s_nxt.rdata = {24'h00_0000, s_r.nv[0]}; // R17
						s_nxt.nv = {s_r.nv[0], s_r.nv[NVB-1:1]}; // R17
					end
				end
				A_RAW_BR: s_nxt.rdata = {18'h0_0000, s_r.br}; // R20
				A_RAW_T:  s_nxt.rdata = {18'h0_0000, s_r.traw}; // R20
				A_RESULT: s_nxt.rdata = {18'h0_0000, s_r.res};
				A_TEMP:   s_nxt.rdata = {24'h00_0000, s_r.temp};
				default:  s_nxt.rdata = 32'h0000_0000;
			endcase
		end
	end

	// Store image is cleared by reset; a real array would keep it
	always_ff @(posedge mclk or posedge reset) begin
		if (reset)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign bus_rdata             = s_r.rdata;
	assign adc_start             = s_r.start;
	assign adc_sel               = s_r.sel;
	assign bridge_sink_on        = s_r.sink;
	assign pamp_gain_sel         = s_r.sh[B_CFG][CFG_GAIN+:2]; // R4
	assign polarity_flip         = s_r.sh[B_CFG][CFG_FLIP]; // R5
	assign adc_zero_point_select = s_r.sh[B_CFG][CFG_ZP+:2]; // R8
	assign dac_data              = s_r.dac;
	assign dig_bridge            = s_r.res;
	assign dig_temp              = s_r.temp;
	assign out_valid             = s_r.valid;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	sequence conv_launch;
		s_r.start;
	endsequence

	sequence conv_finish;
		(s_r.st == ST_CONV) && adc_done;
	endsequence

	sequence nv_write_taken;
		bus_wr && (bus_addr == A_NV) && nv_ok;
	endsequence

	sink_on_a: assert property (conv_launch |-> s_r.sink && (s_r.st == ST_CONV)) // R3
		else $error("sink not on at conversion start");
	sink_off_a: assert property (conv_finish |=> !s_r.sink) // R3
		else $error("sink still on after conversion");
	clip_upper_a: assert property (s_r.valid |-> s_r.res <= up_th) // R22
		else $error("result above upper threshold");
	clip_lower_a: assert property (s_r.valid |-> s_r.res >= lo_th) // R22
		else $error("result below lower threshold");
	dac_path_a: assert property (s_r.valid |-> s_r.dac == s_r.res[13:2]) // R23
		else $error("output converter word not from result");
	load_first_a: assert property (!s_r.loaded |-> !s_r.valid && !s_r.start) // R26
		else $error("activity before coefficients loaded");
	prog_hold_a: assert property (nv_write_taken |=> (s_r.busy_cnt != 17'h0)[*8]) // R18
		else $error("store busy dropped early");
	prog_reload_a: assert property (s_r.busy_cnt == 17'h1 |=> s_r.st == ST_LOAD) // R26
		else $error("no reload after programming");
	raw_temp_a: assert property (bus_rd && (bus_addr == A_RAW_T) |=>
		bus_rdata == {18'h0_0000, $past(s_r.traw)}) // R20
		else $error("raw temperature read wrong");
	temp_byte_a: assert property (s_r.st == ST_CALC |=> dig_temp == $past(tc14[13:6])) // R2
		else $error("temperature byte not top bits");

endmodule : bscd_core

// File: sim/bscd_adc_model.sv
// Behavioural converter standing behind the correction core.
// Assumes one conversion at a time; answer delay varies from prompt to slow.
`timescale 1ns/1ps

module bscd_adc_model (
	input  wire logic        mclk,
	input  wire logic        reset,
	input  wire logic        adc_start,
	input  wire logic [1:0]  adc_sel,
	input  wire logic [13:0] az_v,
	input  wire logic [13:0] br_v,
	input  wire logic [13:0] t_v,
	output logic             adc_done,
	output logic      [13:0] adc_data
);
	logic       busy_r;
	logic [4:0] wait_r;
	logic [1:0] n_r;
	logic [13:0] pick;

	assign pick = (adc_sel == 2'h0) ? az_v : ((adc_sel == 2'h1) ? br_v : t_v);

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			adc_done <= 1'b0;
			adc_data <= 14'h0000;
			busy_r   <= 1'b0;
			wait_r   <= 5'h00;
			n_r      <= 2'h0;
		end else begin
			adc_done <= 1'b0;
			// No hold outside the done cycle
			adc_data <= ~adc_data;
			if (adc_start) begin
				busy_r <= 1'b1;
				wait_r <= (n_r == 2'h0) ? 5'h02 : {n_r, 3'h1};
				n_r    <= n_r + 2'h1;
			end else if (busy_r) begin
				if (wait_r == 5'h00) begin
					busy_r   <= 1'b0;
					adc_done <= 1'b1;
					adc_data <= pick;
				end else begin
					wait_r <= wait_r - 5'h01;
				end
			end
		end
	end
endmodule : bscd_adc_model

// File: sim/bscd_core_bench.sv
// Self-checking bench for the bridge correction core.
// Assumes short conversion and programming counts set through parameters.
`timescale 1ns/1ps

module bscd_core_bench;
	import bscd_pkg::*;
	localparam int CP = 50;
	logic          mclk = 0, reset = 1, bus_wr = 0, bus_rd = 0, prog = 1;
	logic [AW-1:0] bus_addr = '0;
	logic [31:0]   bus_wdata = '0, bus_rdata, rv;
	logic          adc_start, adc_done, bridge_sink_on, polarity_flip, out_valid, dd;
	logic [1:0]    adc_sel, pamp_gain_sel, adc_zero_point_select, last_sel;
	logic [13:0]   adc_data, dig_bridge, az_v = '0, br_v = '0, t_v = '0;
	logic [11:0]   dac_data;
	logic [7:0]    dig_temp;
	logic [7:0]    img [NVB];
	integer        seed = 32'ha14a_709b, bad_count = 0, tests_run = 0, cyc = 0, last_t = 0;

	bscd_core #(.CONV_CYC_P(CP), .NV_PROG_CYC_P(20)) DUT (
		.mclk(mclk), .reset(reset), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
		.bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .adc_start(adc_start),
		.adc_sel(adc_sel), .adc_done(adc_done), .adc_data(adc_data),
		.bridge_sink_on(bridge_sink_on), .pamp_gain_sel(pamp_gain_sel),
		.polarity_flip(polarity_flip), .adc_zero_point_select(adc_zero_point_select),
		.dac_data(dac_data), .dig_bridge(dig_bridge), .dig_temp(dig_temp),
		.out_valid(out_valid));

	bscd_adc_model ADC (.mclk(mclk), .reset(reset), .adc_start(adc_start),
		.adc_sel(adc_sel), .az_v(az_v), .br_v(br_v), .t_v(t_v), .adc_done(adc_done),
		.adc_data(adc_data));

	initial begin
		forever #25 mclk = ~mclk;
	end

	task results;
		if (bad_count == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : results

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	function automatic logic signed [63:0] w16(input int i);
		return $signed({img[i+1], img[i]});
	endfunction : w16

	function automatic logic signed [63:0] sat(input logic signed [63:0] v);
		return (v < 0) ? 64'sh0 : ((v > SAT_MAX) ? SAT_MAX : v);
	endfunction : sat

	function automatic logic [13:0] exp_br(input logic [11:0] tsl);
		logic signed [63:0] raw, dt, tco, tcg, second_order_coef, x, gf, zb, o;
		logic [1:0]  tg;
		logic [13:0] up, lo;
		tg = img[B_CFG][6:5];
		second_order_coef = w16(B_SOT);
		tco = w16(B_TCO);
		tcg = w16(B_TCG);
		raw = $signed({50'h0, br_v}) - $signed({50'h0, az_v});
		dt = $signed({52'h0, t_v[13:2]}) - $signed({52'h0, tsl});
		if (tg == SOT_TCO) tco = tco + ((second_order_coef * dt) >>> SH_SOT);
		if (tg == SOT_TCG) tcg = tcg + ((second_order_coef * dt) >>> SH_SOT);
		x = img[B_CFG][CFG_OSIGN] ? raw + w16(B_OFFB) : raw - w16(B_OFFB);
		x = x + ((dt * tco) >>> SH_TC);
		gf = ONE_Q14 + ((dt * tcg) >>> SH_TC);
		zb = sat((((w16(B_GAINB) * gf) >>> SH_G) * x) >>> SH_Z);
		o = (tg == SOT_BR) ? sat((zb * (K125_Q14 + ((second_order_coef * zb) >>> SH_Z))) >>> SH_Z) : zb;
		up = {2'h3, img[B_UP][6:0], 5'h1f};
		lo = {2'h0, img[B_LO][6:0], 5'h00};
		return (o > up) ? up : ((o < lo) ? lo : o[13:0]);
	endfunction : exp_br

	function automatic logic [7:0] exp_t();
		logic signed [63:0] v;
		v = $signed({56'h0, img[B_GAINT]}) * ($signed({52'h0, t_v[13:2]}) + $signed(img[B_OFFT]));
		v = sat(v >>> SH_T);
		return v[13:6];
	endfunction : exp_t

	task wr(input logic [AW-1:0] a, input logic [31:0] d);
		@(posedge mclk);
		bus_addr <= a;
		bus_wdata <= d;
		bus_wr <= 1'b1;
		@(posedge mclk);
		bus_wr <= 1'b0;
	endtask : wr

	task rd(input logic [AW-1:0] a);
		@(posedge mclk);
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge mclk);
		bus_rd <= 1'b0;
		@(negedge mclk);
		rv = bus_rdata;
	endtask : rd

	// Polling keeps the host off the store while it programs
	task ready;
		for (int i = 0; i < 400; i++) begin
			rd(A_STATUS);
			if (rv[3] === 1'b1 && rv[2] === 1'b0) break;
		end
	endtask : ready

	task prog_nv;
		prog = 1;
		for (int i = 0; i < NVB; i++) begin
			ready();
			wr(A_NV, {24'h0, img[i]});
			if (i == 0) begin
				rd(A_NV);
				chk(rv, 32'h0);
				wr(A_NV, 32'h0000_00a5);
			end
		end
		ready();
		// Let a conversion cut by the reload drain out of the converter
		repeat (30) @(posedge mclk);
		last_t = 0;
		prog = 0;
	endtask : prog_nv

	task wait_ov;
		for (int i = 0; i < 4000; i++) begin
			@(negedge mclk);
			if (out_valid === 1'b1) break;
		end
	endtask : wait_ov

	task check_out(input logic [11:0] tsl);
		wait_ov();
		wait_ov();
		chk(dig_bridge, exp_br(tsl));
		chk(dac_data, exp_br(tsl) >> 2);
		chk(dig_temp, exp_t());
	endtask : check_out

	// Watch the converter handshake and slot timing
	always @(negedge mclk) begin
		cyc++;
		if (cyc > 60000) begin
			bad_count++;
			results();
		end
		if (!prog && dd === 1'b1) chk(32'(bridge_sink_on), 32'h0);
		if (!prog && adc_done === 1'b1) chk(32'(bridge_sink_on), 32'h1);
		dd = adc_done;
		if (adc_start === 1'b1) begin
			if (adc_sel !== SEL_AZ) chk(adc_sel, last_sel + 2'h1);
			if (!prog && last_t != 0) chk(cyc - last_t, CP * (img[B_RATE][0] ? 5 : 1));
			last_sel = adc_sel;
			last_t = cyc;
		end
	end

	initial begin
		for (int i = 0; i < NVB; i++) img[i] = 8'h00;
		repeat (15) @(posedge mclk);
		@(negedge mclk);
		chk(32'({out_valid, bridge_sink_on, adc_start, dac_data, dig_bridge}), 32'h0);
		@(posedge mclk);
		reset <= 1'b0;
		az_v <= $random(seed);
		br_v <= $random(seed);
		t_v <= $random(seed);
		ready();
		rd(8'h1c);
		chk(rv, 32'h0);
		check_out(12'h000);
		for (int k = 0; k < 4; k++) begin
			for (int i = 0; i < NVB; i++) img[i] = $random(seed);
			img[B_CFG][6:5] = 2'(k);
			img[B_RATE] = {7'h00, img[B_RATE][0]};
			img[B_GAINB+1][7:6] = 2'h0;
			img[B_OFFB+1][7:5] = 3'h0;
			img[B_TCO+1] = 8'h00;
			img[B_TCG+1] = 8'h00;
			img[B_SOT+1] = 8'h00;
			@(posedge mclk);
			az_v <= {2'h0, 12'($random(seed))};
			br_v <= $random(seed);
			t_v <= $random(seed);
			prog_nv();
			for (int i = 0; i < NVB; i++) begin
				rd(A_NV);
				chk(rv, {24'h0, img[i]});
			end
			chk(pamp_gain_sel, img[B_CFG][1:0]);
			chk(polarity_flip, img[B_CFG][CFG_FLIP]);
			chk(adc_zero_point_select, img[B_CFG][4:3]);
			check_out({img[B_TSETL+1][3:0], img[B_TSETL]});
			if (k == 0) begin
				wr(A_CMD, {24'h0, CMD_CAL_LOW});
				check_out(t_v[13:2]);
			end
		end
		results();
	end
endmodule : bscd_core_bench
